// File: logic/urf_pkg.sv
// Purpose: Shared constants and types for the flow-controlled serial port ends
// Assumes: 10 MHz system clock, fixed 8-N-1 framing
package urf_pkg;
    localparam int CLK_HZ          = 10_000_000;
    localparam int MAX_BAUD        = 2_000_000;
    localparam int DATA_BITS       = 8;
    localparam int RX_DEPTH        = 1024;
    localparam int RTS_MARGIN      = 16;
    localparam int SKID_DEPTH      = 2;
    localparam int HOST_RX_DEPTH   = 2;
    localparam int HOST_RTS_MARGIN = 1;
    localparam int CNT_W           = 16;
    localparam logic IDLE_LEVEL    = 1'b1;
    localparam logic RTS_ASSERTED  = 1'b0;
    localparam logic RTS_RELEASED  = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } urf_state_type;
endpackage

// File: logic/urf_link_if.sv
// Purpose: Four-wire serial link between module end and host end
// Assumes: Both ends on the same clk
// Notes:   No pull-ups here; every wire is always driven by its owner
`timescale 1ns/100ps
interface urf_link_if;
    logic gp_pin_serial_out;   // Module transmit, idle high
    logic gp_pin_request_out;  // Module RTS, active low
    logic host_txd;            // Host transmit, idle high
    logic host_rts_n;          // Host RTS, active low
    logic gp_pin_serial_in;
    logic gp_pin_clear_in;

    // Crossed wiring: host TXD to module RX, host RTS to module CTS
    assign gp_pin_serial_in = host_txd;
    assign gp_pin_clear_in  = host_rts_n;

    modport dev (
        output gp_pin_serial_out,
        output gp_pin_request_out,
        input  gp_pin_serial_in,
        input  gp_pin_clear_in
    );
    modport host (
        output host_txd,
        output host_rts_n,
        input  gp_pin_serial_out,
        input  gp_pin_request_out
    );
endinterface

// File: logic/urf_dev.sv
// Purpose: Module end of the serial port, plus shared buffer and bit engines
// Assumes: urf_pkg compiled first; clear and receive pins are asynchronous
// Notes:   Buffers have a registered head word, so capacity is DEPTH plus one
`timescale 1ns/100ps

// ------------------------------------------------------------
// Buffer with registered head word
// ------------------------------------------------------------
module urf_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    // Fill side
    input  wire logic                     in_valid,
    input  wire logic [W-1:0]             in_data,
    output logic                          in_ready,
    // Drain side
    input  wire logic                     out_ready,
    output logic                          out_valid,
    output logic [W-1:0]                  out_data,
    // Words held in memory
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] next_level;
    wire           push = in_valid && in_ready && ce;
    wire           load = (!out_valid || out_ready) && (level != '0) && ce;

    // Occupancy after this cycle's push and pop
    assign next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

    // Storage array, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    // Pointers and head word; ready is registered to keep outputs on flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wptr      <= '0;
            rptr      <= '0;
            level     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (ce) begin
            level    <= next_level;
            in_ready <= next_level < CW'(DEPTH);
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (load) begin
                out_data  <= mem[rptr];
                out_valid <= 1'b1;
                rptr      <= rptr + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Character transmitter
// ------------------------------------------------------------
module urf_tx import urf_pkg::*; #(
    parameter int DIV = 5
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Character in
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output logic            in_ready,
    // Flow control and line
    input  wire logic       clear_ok,
    output logic            line
);
    urf_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       bit_idx;
    logic [7:0]       shift;
    wire              tick = cnt == CNT_W'(DIV - 1);

    // A new character starts only while the far end grants it
    assign in_ready = (state == ST_IDLE) && clear_ok;

    // One bit period per state step, LSB first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state   <= ST_IDLE;
            cnt     <= '0;
            bit_idx <= '0;
            shift   <= '0;
            line    <= IDLE_LEVEL;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    line <= IDLE_LEVEL;
                    cnt  <= '0;
                    if (in_valid && clear_ok) begin
                        shift <= in_data;
                        line  <= 1'b0;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    cnt <= tick ? '0 : cnt + 1'b1;
                    if (tick) begin
                        line    <= shift[0];
                        bit_idx <= '0;
                        state   <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    cnt <= tick ? '0 : cnt + 1'b1;
                    if (tick && bit_idx == 3'(DATA_BITS - 1)) begin
                        line  <= 1'b1;
                        state <= ST_STOP;
                    end else if (tick) begin
                        bit_idx <= bit_idx + 1'b1;
                        shift   <= shift >> 1;
                        line    <= shift[1];
                    end
                end
                ST_STOP: begin
                    cnt <= tick ? '0 : cnt + 1'b1;
                    if (tick) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ------------------------------------------------------------
// Character receiver, line must already be synchronised
// ------------------------------------------------------------
module urf_rx import urf_pkg::*; #(
    parameter int DIV = 5
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Line and result
    input  wire logic       line,
    output logic            out_valid,
    output logic [7:0]      out_data,
    output logic            frame_err
);
    urf_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       bit_idx;
    logic [7:0]       shift;
    wire              tick = cnt == CNT_W'(DIV - 1);
    wire              mid  = cnt == CNT_W'(DIV / 2);

    // Sample at mid-bit; a short low glitch is dropped at the start check
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= ST_IDLE;
            cnt       <= '0;
            bit_idx   <= '0;
            shift     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
            frame_err <= 1'b0;
        end else if (ce) begin
            out_valid <= 1'b0;
            frame_err <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cnt <= '0;
                    if (!line) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    cnt <= cnt + 1'b1;
                    if (mid) begin
                        cnt     <= '0;
                        bit_idx <= '0;
                        state   <= line ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    cnt <= tick ? '0 : cnt + 1'b1;
                    if (tick) begin
                        shift   <= {line, shift[7:1]};
                        bit_idx <= bit_idx + 1'b1;
                        if (bit_idx == 3'(DATA_BITS - 1)) begin
                            state <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    cnt <= tick ? '0 : cnt + 1'b1;
                    if (tick) begin
                        state     <= ST_IDLE;
                        out_valid <= line;
                        out_data  <= shift;
                        frame_err <= !line;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ------------------------------------------------------------
// Module end
// ------------------------------------------------------------
module urf_dev import urf_pkg::*; #(
    parameter int BAUD     = MAX_BAUD,
    parameter int DEPTH    = RX_DEPTH,
    parameter int MARGIN   = RTS_MARGIN
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Characters to send
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Characters received
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_error,
    // Serial link
    urf_link_if.dev         link
);
    localparam int DIV = CLK_HZ / BAUD;
    localparam int LW  = $clog2(DEPTH) + 1;

    logic          in_meta;
    logic          in_sync;
    logic          clr_meta;
    logic          clr_sync;
    logic          buf_valid;
    logic [7:0]    buf_data;
    logic          eng_ready;
    logic          got_valid;
    logic [7:0]    got_data;
    logic          got_err;
    logic          store_ready;
    logic [LW-1:0] store_level;
    wire           clear_ok = clr_sync == RTS_ASSERTED;
    wire           overrun  = got_valid && !store_ready;
    wire           nearly   = store_level >= LW'(DEPTH - MARGIN);

    // Pins from the host pass two flops; reset reads idle and deasserted
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_meta  <= IDLE_LEVEL;
            in_sync  <= IDLE_LEVEL;
            clr_meta <= RTS_RELEASED;
            clr_sync <= RTS_RELEASED;
        end else if (ce) begin
            in_meta  <= link.gp_pin_serial_in;
            in_sync  <= in_meta;
            clr_meta <= link.gp_pin_clear_in;
            clr_sync <= clr_meta;
        end
    end

    // Three-word buffer, two in memory plus the head word, so a stalled transmitter loses nothing
    urf_fifo #(.W(8), .DEPTH(SKID_DEPTH)) tx_buf (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .in_valid(tx_valid), .in_data(tx_data), .in_ready(tx_ready),
        .out_ready(eng_ready), .out_valid(buf_valid), .out_data(buf_data),
        .level()
    );

    // Transmit path runs apart from receive
    urf_tx #(.DIV(DIV)) tx_eng (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .in_valid(buf_valid), .in_data(buf_data), .in_ready(eng_ready),
        .clear_ok(clear_ok), .line(link.gp_pin_serial_out)
    );

    urf_rx #(.DIV(DIV)) rx_eng (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .line(in_sync), .out_valid(got_valid), .out_data(got_data),
        .frame_err(got_err)
    );

    // Deep receive store
    urf_fifo #(.W(8), .DEPTH(DEPTH)) rx_store (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .in_valid(got_valid), .in_data(got_data), .in_ready(store_ready),
        .out_ready(rx_ready), .out_valid(rx_valid), .out_data(rx_data),
        .level(store_level)
    );

    // RTS drops with margin left for bytes already on the wire
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.gp_pin_request_out <= RTS_ASSERTED;
            rx_error                <= 1'b0;
        end else if (ce) begin
            link.gp_pin_request_out <= nearly ? RTS_RELEASED : RTS_ASSERTED;
            rx_error                <= got_err || overrun;
        end
    end
endmodule

// File: logic/urf_host.sv
// Purpose: Host end of the serial port
// Assumes: urf_dev.sv compiled first for the shared engines and buffer
// Notes:   RTS and CTS are never tied together here
`timescale 1ns/100ps

// ------------------------------------------------------------
// Host end
// ------------------------------------------------------------
module urf_host import urf_pkg::*; #(
    parameter int BAUD   = MAX_BAUD,
    parameter int DEPTH  = HOST_RX_DEPTH,
    parameter int MARGIN = HOST_RTS_MARGIN
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // Characters to send
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Characters received
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_error,
    // Serial link
    urf_link_if.host        link
);
    localparam int DIV = CLK_HZ / BAUD;
    localparam int LW  = $clog2(DEPTH) + 1;

    logic          in_meta;
    logic          in_sync;
    logic          clr_meta;
    logic          clr_sync;
    logic          buf_valid;
    logic [7:0]    buf_data;
    logic          eng_ready;
    logic          got_valid;
    logic [7:0]    got_data;
    logic          got_err;
    logic          store_ready;
    logic [LW-1:0] store_level;
    wire           clear_ok = clr_sync == RTS_ASSERTED;
    wire           overrun  = got_valid && !store_ready;
    wire           nearly   = store_level >= LW'(DEPTH - MARGIN);

    // Module pins pass two flops before use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_meta  <= IDLE_LEVEL;
            in_sync  <= IDLE_LEVEL;
            clr_meta <= RTS_RELEASED;
            clr_sync <= RTS_RELEASED;
        end else if (ce) begin
            in_meta  <= link.gp_pin_serial_out;
            in_sync  <= in_meta;
            clr_meta <= link.gp_pin_request_out;
            clr_sync <= clr_meta;
        end
    end

    urf_fifo #(.W(8), .DEPTH(SKID_DEPTH)) tx_buf (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .in_valid(tx_valid), .in_data(tx_data), .in_ready(tx_ready),
        .out_ready(eng_ready), .out_valid(buf_valid), .out_data(buf_data),
        .level()
    );

    // Sending holds off while the module's RTS is high
    urf_tx #(.DIV(DIV)) tx_eng (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .in_valid(buf_valid), .in_data(buf_data), .in_ready(eng_ready),
        .clear_ok(clear_ok), .line(link.host_txd)
    );

    urf_rx #(.DIV(DIV)) rx_eng (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .line(in_sync), .out_valid(got_valid), .out_data(got_data),
        .frame_err(got_err)
    );

    urf_fifo #(.W(8), .DEPTH(DEPTH)) rx_store (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .in_valid(got_valid), .in_data(got_data), .in_ready(store_ready),
        .out_ready(rx_ready), .out_valid(rx_valid), .out_data(rx_data),
        .level(store_level)
    );

    // Small store, so RTS drops as soon as one word waits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.host_rts_n <= RTS_ASSERTED;
            rx_error        <= 1'b0;
        end else if (ce) begin
            link.host_rts_n <= nearly ? RTS_RELEASED : RTS_ASSERTED;
            rx_error        <= got_err || overrun;
        end
    end
endmodule

// File: tb/urf_checker.sv
// Purpose: Checks on the four link wires between both serial ends
// Assumes: Default bit rate, so five clocks a bit
// Notes:   A frame counter tells a start bit from a falling data bit
`timescale 1ns/100ps
module urf_checker import urf_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link wires
    input wire logic gp_pin_serial_out,
    input wire logic gp_pin_request_out,
    input wire logic host_txd,
    input wire logic host_rts_n
);
    // ----------------------------------------
    // Frame tracking
    // ----------------------------------------
    localparam logic [5:0] FRAME_LAST = 6'h31; // Ten bits of five clocks, minus one
    logic       prev_d;
    logic       prev_h;
    logic [5:0] cnt_d;
    logic [5:0] cnt_h;
    wire        start_d    = prev_d & ~gp_pin_serial_out & (cnt_d == 6'h00);
    wire        start_h    = prev_h & ~host_txd & (cnt_h == 6'h00);
    wire  [5:0] next_cnt_d = start_d ? FRAME_LAST : cnt_d - {5'h00, |cnt_d};
    wire  [5:0] next_cnt_h = start_h ? FRAME_LAST : cnt_h - {5'h00, |cnt_h};

    // A fall counts as a start only once the previous frame has run out
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_d <= 1'b1;
            prev_h <= 1'b1;
            cnt_d  <= 6'h00;
            cnt_h  <= 6'h00;
        end else begin
            prev_d <= gp_pin_serial_out;
            prev_h <= host_txd;
            cnt_d  <= next_cnt_d;
            cnt_h  <= next_cnt_h;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_DEV_INIT: assert property ($fell(sys_rst) |->
        gp_pin_serial_out && !gp_pin_request_out) else $error("module lines wrong after reset");
    AST_HOST_INIT: assert property ($fell(sys_rst) |-> host_txd && !host_rts_n)
        else $error("host lines wrong after reset");
    // Every level on a data line lasts a whole bit of five clocks
    AST_DEV_BIT: assert property ($changed(gp_pin_serial_out) |=>
        $stable(gp_pin_serial_out)[*4]) else $error("module bit shorter than five clocks");
    AST_HOST_BIT: assert property ($changed(host_txd) |=> $stable(host_txd)[*4])
        else $error("host bit shorter than five clocks");
    // Synchroniser lag is allowed some slack, a steady refusal is not
    AST_DEV_CTS: assert property (start_d |-> !$past(host_rts_n, 2) ||
        !$past(host_rts_n, 3) || !$past(host_rts_n, 4)) else $error("module sent without grant");
    AST_HOST_CTS: assert property (start_h |-> !$past(gp_pin_request_out, 2) ||
        !$past(gp_pin_request_out, 3) || !$past(gp_pin_request_out, 4))
        else $error("host sent while module refused");
    AST_DEV_STOP: assert property (cnt_d == 6'h03 |-> gp_pin_serial_out)
        else $error("module stop bit low");
    AST_HOST_STOP: assert property (cnt_h == 6'h03 |-> host_txd)
        else $error("host stop bit low");

    // Main scenarios reached
    CVR_DEV_FRAME: cover property (start_d);
    CVR_HOST_FRAME: cover property (start_h);
    CVR_DEV_REFUSE: cover property ($rose(gp_pin_request_out));
    CVR_HOST_REFUSE: cover property ($rose(host_rts_n));
endmodule

// File: tb/uart_with_rts_cts_flow_tb.sv
// Purpose: Self-checking bench joining module end and host end
// Assumes: Default bit rate, module store shrunk to 16 with margin 4
// Notes:   A second module end takes frames from a bench bit driver
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("mismatch at %0t: got %0h", $time, got); \
    end \
end
module uart_with_rts_cts_flow_tb import urf_pkg::*;;
    // ----------------------------------------
    // Signals and ends
    // ----------------------------------------
    logic       clk;
    logic       sys_rst;
    logic       ce;
    logic       d_txv, h_txv, d_rxr, h_rxr, bang_line;
    logic [7:0] d_txd, h_txd, d_rxd, h_rxd, e_rxd;
    logic       d_txr, h_txr, d_rxv, h_rxv, d_err, h_err, e_rxv, e_err;
    logic [1:0] d_mode, h_mode;
    int         fail_count, compares, err2;
    logic [7:0] q_d2h[$], q_h2d[$], q_e[$];
    urf_link_if link ();
    urf_link_if link2 ();
    wire  [1:0] tx_lines = {link.host_txd, link.gp_pin_serial_out};

    // Faulty sender on the second link; its grant stays up
    assign link2.host_txd   = bang_line;
    assign link2.host_rts_n = RTS_ASSERTED;

    urf_dev #(.DEPTH(16), .MARGIN(4)) urf_dev_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tx_valid(d_txv), .tx_data(d_txd), .tx_ready(d_txr), .rx_ready(d_rxr),
        .rx_valid(d_rxv), .rx_data(d_rxd), .rx_error(d_err), .link(link.dev));
    // Host keeps its own request and grant apart
    urf_host urf_host_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tx_valid(h_txv), .tx_data(h_txd), .tx_ready(h_txr), .rx_ready(h_rxr),
        .rx_valid(h_rxv), .rx_data(h_rxd), .rx_error(h_err), .link(link.host));
    urf_dev #(.DEPTH(16), .MARGIN(4)) urf_dev_fault_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tx_valid(1'b0), .tx_data(8'h00), .tx_ready(), .rx_ready(1'b1),
        .rx_valid(e_rxv), .rx_data(e_rxd), .rx_error(e_err), .link(link2.dev));
    urf_checker urf_checker_i (.clk(clk), .sys_rst(sys_rst),
        .gp_pin_serial_out(link.gp_pin_serial_out), .gp_pin_request_out(link.gp_pin_request_out),
        .host_txd(link.host_txd), .host_rts_n(link.host_rts_n));

    // ----------------------------------------
    // Clock, readiness and result watcher
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Readiness modes: 0 stall, 1 ready, 2 random
    always @(posedge clk) begin
        d_rxr <= (d_mode == 2'h2) ? 1'($urandom_range(0, 1)) : d_mode[0];
        h_rxr <= (h_mode == 2'h2) ? 1'($urandom_range(0, 1)) : h_mode[0];
    end

    // Oldest note is compared whenever a byte is taken
    always @(posedge clk) begin
        if (sys_rst === 1'b0) begin
            if (h_rxv === 1'b1 && h_rxr === 1'b1) `CHK(h_rxd, q_d2h.pop_front())
            if (d_rxv === 1'b1 && d_rxr === 1'b1) `CHK(d_rxd, q_h2d.pop_front())
            if (e_rxv === 1'b1) `CHK(e_rxd, q_e.pop_front())
            `CHK({d_err, h_err}, 2'b00)
            if (e_err === 1'b1) err2++;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic give_up;
        fail_count++;
        $display("mismatch at %0t: wait ran out", $time);
        tally_and_finish();
    endtask

    // Holds the byte until taken; valid drops only after the last one
    task automatic send(input bit to_host, input logic [7:0] b, input bit last);
        int n;
        n = 0;
        if (to_host) begin
            d_txv <= 1'b1;
            d_txd <= b;
        end else begin
            h_txv <= 1'b1;
            h_txd <= b;
        end
        do begin
            @(posedge clk);
            n++;
        end while ((to_host ? d_txr : h_txr) !== 1'b1 && n < 5000);
        if (n >= 5000) give_up();
        if (to_host) q_d2h.push_back(b);
        else q_h2d.push_back(b);
        if (last && to_host) d_txv <= 1'b0;
        if (last && !to_host) h_txv <= 1'b0;
    endtask

    task automatic burst(input bit to_host, input int count);
        for (int i = 0; i < count; i++) send(to_host, 8'($urandom), i == count - 1);
    endtask

    // Samples one frame at mid-bit straight off a data line
    task automatic wire_look(input bit dev_line, input logic [7:0] b);
        logic [7:0] got;
        int         n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_lines[!dev_line] !== 1'b0 && n < 5000);
        if (n >= 5000) give_up();
        repeat (2) @(posedge clk);
        `CHK(tx_lines[!dev_line], 1'b0)
        for (int i = 0; i < 8; i++) begin
            repeat (5) @(posedge clk);
            got[i] = tx_lines[!dev_line];
        end
        `CHK(got, b)
        repeat (5) @(posedge clk);
        `CHK(tx_lines[!dev_line], IDLE_LEVEL)
    endtask

    // Bench-made frame with a chosen stop level
    task automatic bang(input logic [7:0] b, input logic stop_bit);
        bang_line <= 1'b0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            bang_line <= b[i];
            repeat (5) @(posedge clk);
        end
        bang_line <= stop_bit;
        repeat (5) @(posedge clk);
        bang_line <= 1'b1;
        repeat (20) @(posedge clk);
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (q_d2h.size() + q_h2d.size() + q_e.size() != 0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) give_up();
        repeat (20) @(posedge clk);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge clk);
        give_up();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        {d_txv, h_txv, d_txd, h_txd} = '0;
        {d_rxr, h_rxr, bang_line} = 3'h7;
        {d_mode, h_mode} = 4'h5;
        fail_count = 0;
        compares = 0;
        err2 = 0;
        void'($urandom(32'h89e6));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK(d_txr & h_txr, 1'b1)
        `CHK({d_rxv, h_rxv}, 2'b00)
        `CHK(link.gp_pin_serial_out, IDLE_LEVEL)
        `CHK(link.gp_pin_request_out, RTS_ASSERTED)
        `CHK(link.host_txd & link.gp_pin_serial_in, IDLE_LEVEL)
        `CHK(link.gp_pin_clear_in, RTS_ASSERTED)
        $display("test reset levels done");
        // Both directions at once, each frame read off the wire
        fork
            send(1'b1, 8'hB4, 1'b1);
            send(1'b0, 8'h2D, 1'b1);
            wire_look(1'b1, 8'hB4);
            wire_look(1'b0, 8'h2D);
        join
        drain();
        $display("test duplex wire format done");
        d_mode <= 2'h2;
        h_mode <= 2'h2;
        fork
            burst(1'b1, 40);
            burst(1'b0, 40);
        join
        drain();
        $display("test random duplex with stalls done");
        // Module store held full: request drops and the host must pause
        d_mode <= 2'h0;
        h_mode <= 2'h1;
        fork
            burst(1'b0, 30);
            begin
                for (int n = 0; link.gp_pin_request_out !== RTS_RELEASED; n++) begin
                    if (n >= 3000) give_up();
                    @(posedge clk);
                end
                repeat (200) @(posedge clk);
                for (int n = 0; n < 100; n++) begin
                    `CHK(link.host_txd, IDLE_LEVEL)
                    @(posedge clk);
                end
                `CHK(link.gp_pin_request_out, RTS_RELEASED)
                d_mode <= 2'h1;
            end
        join
        drain();
        `CHK(link.gp_pin_request_out, RTS_ASSERTED)
        $display("test store full done");
        // Enable low freezes both ends while idle
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK({d_txr, link.gp_pin_serial_out, link.gp_pin_request_out}, 3'h6)
        ce <= 1'b1;
        // Bad stop level is dropped and flagged, a good frame follows
        bang(8'h5A, 1'b0);
        `CHK(err2, 1)
        q_e.push_back(8'hC3);
        bang(8'hC3, 1'b1);
        drain();
        `CHK(err2, 1)
        $display("test faulty sender done");
        tally_and_finish();
    end
endmodule
